// ===== verilog/rs_pkg.sv
// Shared constants and types for the rotary selector switch
package rs_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int          RS_MAX_POS   = 32;
  localparam int          RS_POS_W     = 6;
  localparam int          RS_MS_W      = 16;
  localparam int          RS_ADDR_W    = 8;
  localparam logic [5:0]  RS_POS_FIRST = 6'h01;
  localparam logic [5:0]  RS_POS_LAST  = 6'h20;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RS_CLK_NS      = 10;
  localparam int RS_TICK_NS     = 1000000;
  localparam int RS_TICK_CYCLES = RS_TICK_NS / RS_CLK_NS;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RS_REG_CTRL   = 8'h00;
  localparam logic [7:0] RS_REG_DELAY  = 8'h04;
  localparam logic [7:0] RS_REG_PULSE  = 8'h08;
  localparam logic [7:0] RS_REG_CMD    = 8'h0C;
  localparam logic [7:0] RS_REG_STATUS = 8'h10;

  localparam int RS_CTRL_OP      = 0;
  localparam int RS_CTRL_PULSED  = 1;
  localparam int RS_CTRL_ESTOP   = 2;
  localparam int RS_CTRL_CNT_LSB = 8;

  localparam int RS_CMD_LOC_UP = 0;
  localparam int RS_CMD_LOC_DN = 1;
  localparam int RS_CMD_REM_UP = 2;
  localparam int RS_CMD_REM_DN = 3;

  localparam int RS_ST_BUSY      = 8;
  localparam int RS_ST_BLOCKED   = 9;
  localparam int RS_ST_PLACE_LSB = 16;

  localparam logic [31:0] RS_CTRL_RESET  = 32'h0000_2001;
  localparam logic [15:0] RS_DELAY_RESET = 16'h0000;
  localparam logic [15:0] RS_PULSE_RESET = 16'h0064;

  localparam logic [1:0] RS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RS_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Operator place encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] RS_PLACE_LOCAL  = 2'h0;
  localparam logic [1:0] RS_PLACE_REMOTE = 2'h1;
  localparam logic [1:0] RS_PLACE_ALL    = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_PULSE} rs_state_t;

endpackage

// ===== verilog/rs_sync.sv
// Two-stage synchroniser for pin inputs
module rs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// ===== verilog/rs_timer.sv
// Millisecond countdown timer with freeze input
module rs_timer #(
  parameter int TICK_CYCLES = 100000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control
  input  wire logic        start,
  input  wire logic [15:0] len,
  input  wire logic        hold,
  output logic             done
);

  logic [15:0] ms;
  logic [31:0] pre;
  logic        run;
  wire         tick_end = (pre == 32'(TICK_CYCLES - 1));

  // Combinational so a freeze can never swallow the end
  assign done = run && !hold && (ms == 16'h0000);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms  <= 16'h0000;
      pre <= 32'h0000_0000;
      run <= 1'b0;
    end else if (start) begin
      ms  <= len;
      pre <= 32'h0000_0000;
      run <= 1'b1;
    end else if (run && !hold) begin
      if (ms == 16'h0000) begin
        run <= 1'b0;
      end else if (tick_end) begin
        pre <= 32'h0000_0000;
        ms  <= ms - 16'h0001;
      end else begin
        pre <= pre + 32'h0000_0001;
      end
    end
  end

endmodule

// ===== verilog/rs_selector.sv
// Rotary selector switch with AXI4-Lite control
// Behaviour
// - Up and down operating inputs exist, plus a blocking input and an operator place input.
// - The number of the active position is presented as an integer output.
// - The position count is set by software and never exceeds 32.
// - Only the first position_count outputs can ever be driven high.
// - A style setting picks a steady level or a pulse for the active output.
// - In pulsed style the output pulse lasts the configured pulse length.
// - A new position is taken only after the activation delay from the command edge.
// - Without end stop, up at the first position goes to the last, down at the last to the first.
// - With end stop, a command that would wrap leaves the position unchanged.
// - With operation off, commands are ignored.
// - Commands come from the local panel, from binary inputs and from a remote station.
module rs_selector
  import rs_pkg::*;
#(
  parameter int TICK_CYCLES = rs_pkg::RS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // AXI4-Lite write address and data
  input  wire logic [rs_pkg::RS_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read
  input  wire logic [rs_pkg::RS_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Pins
  input  wire logic                          bin_up,
  input  wire logic                          bin_down,
  input  wire logic                          block,
  input  wire logic [1:0]                    operator_place_select,
  // Switch outputs
  output logic [rs_pkg::RS_POS_W-1:0]        position_number,
  output logic [rs_pkg::RS_MAX_POS-1:0]      position_out
);

  import rs_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pins_s;
  logic       bin_up_q;
  logic       bin_dn_q;

  rs_sync #(.W(5)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({operator_place_select, block, bin_down, bin_up}),
    .dout (pins_s)
  );

  wire       blocked  = pins_s[2];
  wire [1:0] place    = pins_s[4:3];
  wire       bin_up_r = pins_s[0] && !bin_up_q;
  wire       bin_dn_r = pins_s[1] && !bin_dn_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bin_up_q <= 1'b0;
      bin_dn_q <= 1'b0;
    end else begin
      bin_up_q <= pins_s[0];
      bin_dn_q <= pins_s[1];
    end
  end

  // ----------------------------------------------------------------
  // Register file and AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [31:0]          ctrl;
  logic [15:0]          delay_ms;
  logic [15:0]          pulse_ms;
  logic                 aw_full;
  logic                 w_full;
  logic [RS_ADDR_W-1:0] aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic [RS_POS_W-1:0]  position;
  rs_state_t            state;

  wire [31:0] wmask    = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire        do_write = aw_full && w_full && !s_axi_bvalid;
  wire        wr_ctrl  = do_write && (aw_addr == RS_REG_CTRL);
  wire        wr_delay = do_write && (aw_addr == RS_REG_DELAY);
  wire        wr_pulse = do_write && (aw_addr == RS_REG_PULSE);
  wire        wr_cmd   = do_write && (aw_addr == RS_REG_CMD);
  wire        wr_hit   = wr_ctrl || wr_delay || wr_pulse || wr_cmd || (aw_addr == RS_REG_STATUS);
  wire [31:0] next_ctrl  = (ctrl & ~wmask) | (w_data & wmask);
  wire [31:0] next_delay = ({16'h0000, delay_ms} & ~wmask) | (w_data & wmask);
  wire [31:0] next_pulse = ({16'h0000, pulse_ms} & ~wmask) | (w_data & wmask);
  wire [3:0]  sw_cmd     = wr_cmd ? (w_data[3:0] & wmask[3:0]) : 4'h0;

  wire        busy        = (state != ST_IDLE);
  wire [31:0] status_word = {14'h0000, place, 6'h00, blocked, busy, 2'h0, position};
  wire        rd_hit      = (s_axi_araddr == RS_REG_CTRL) || (s_axi_araddr == RS_REG_DELAY) ||
                            (s_axi_araddr == RS_REG_PULSE) || (s_axi_araddr == RS_REG_CMD) ||
                            (s_axi_araddr == RS_REG_STATUS);
  wire [31:0] rd_word     = (s_axi_araddr == RS_REG_CTRL)   ? ctrl :
                            (s_axi_araddr == RS_REG_DELAY)  ? {16'h0000, delay_ms} :
                            (s_axi_araddr == RS_REG_PULSE)  ? {16'h0000, pulse_ms} :
                            (s_axi_araddr == RS_REG_STATUS) ? status_word : 32'h0000_0000;

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RS_RESP_OKAY : RS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? rd_word : 32'h0000_0000;
      s_axi_rresp  <= rd_hit ? RS_RESP_OKAY : RS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl     <= RS_CTRL_RESET;
      delay_ms <= RS_DELAY_RESET;
      pulse_ms <= RS_PULSE_RESET;
    end else begin
      if (wr_ctrl) ctrl <= next_ctrl;
      if (wr_delay) delay_ms <= next_delay[15:0];
      if (wr_pulse) pulse_ms <= next_pulse[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Settings decode
  // ----------------------------------------------------------------
  wire                ctrl_op     = ctrl[RS_CTRL_OP];
  wire                ctrl_pulsed = ctrl[RS_CTRL_PULSED];
  wire                ctrl_estop  = ctrl[RS_CTRL_ESTOP];
  wire [RS_POS_W-1:0] cnt_field   = ctrl[RS_CTRL_CNT_LSB +: RS_POS_W];
  // Out-of-range counts are clamped rather than refused
  wire [RS_POS_W-1:0] eff_cnt     = (cnt_field == 6'h00) ? RS_POS_FIRST :
                                    (cnt_field > RS_POS_LAST) ? RS_POS_LAST : cnt_field;
  wire [32:0]         mask_wide   = (33'h0_0000_0001 << eff_cnt) - 33'h0_0000_0001;
  wire [31:0]         pos_mask    = mask_wide[31:0];
  wire [31:0]         pos_hot     = 32'h0000_0001 << (position - RS_POS_FIRST);
  wire [31:0]         hot_masked  = pos_hot & pos_mask;

  // ----------------------------------------------------------------
  // Command sources
  // ----------------------------------------------------------------
  wire loc_ok = (place == RS_PLACE_LOCAL) || (place == RS_PLACE_ALL);
  wire rem_ok = (place == RS_PLACE_REMOTE) || (place == RS_PLACE_ALL);
  wire up_evt = bin_up_r || (loc_ok && sw_cmd[RS_CMD_LOC_UP]) ||
                (rem_ok && sw_cmd[RS_CMD_REM_UP]);
  wire dn_evt = bin_dn_r || (loc_ok && sw_cmd[RS_CMD_LOC_DN]) ||
                (rem_ok && sw_cmd[RS_CMD_REM_DN]);
  // Edges arriving mid-step are dropped; spacing them out is the caller's job
  wire accept = (state == ST_IDLE) && ctrl_op && !blocked && (up_evt || dn_evt);

  // ----------------------------------------------------------------
  // Next position
  // ----------------------------------------------------------------
  logic [RS_POS_W-1:0] target;
  wire  [RS_POS_W-1:0] up_pos = (position <= RS_POS_FIRST) ?
                                (ctrl_estop ? position : eff_cnt) : position - RS_POS_FIRST;
  wire  [RS_POS_W-1:0] dn_pos = (position >= eff_cnt) ?
                                (ctrl_estop ? position : RS_POS_FIRST) : position + RS_POS_FIRST;
  wire  [RS_POS_W-1:0] next_target = up_evt ? up_pos : dn_pos;

  // ----------------------------------------------------------------
  // Step sequencer
  // ----------------------------------------------------------------
  logic t_done;
  wire  delay_end = (state == ST_DELAY) && t_done && !blocked;
  wire  t_start   = accept || (delay_end && ctrl_pulsed);
  wire  [15:0] t_len = accept ? delay_ms : pulse_ms;

  rs_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (t_start),
    .len   (t_len),
    .hold  (blocked),
    .done  (t_done)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= ST_IDLE;
      position <= RS_POS_FIRST;
      target   <= RS_POS_FIRST;
    end else if (!ctrl_op) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (accept) begin
            target <= next_target;
            state  <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (delay_end) begin
            position <= target;
            state    <= ctrl_pulsed ? ST_PULSE : ST_IDLE;
          end
        end
        ST_PULSE: begin
          if (t_done && !blocked) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire        show_out = !ctrl_pulsed || (state == ST_PULSE);
  wire [31:0] next_out = (ctrl_op && show_out) ? hot_masked : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      position_out <= 32'h0000_0000;
    end else if (!blocked || !ctrl_op) begin
      position_out <= next_out;
    end
  end

  assign position_number = position;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [63:0] ph_cnt;
  logic [15:0] len_snap;
  rs_state_t   state_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_cnt   <= 64'h0;
      len_snap <= 16'h0000;
      state_q  <= ST_IDLE;
    end else begin
      state_q <= state;
      if (t_start) len_snap <= t_len;
      if (state != state_q) ph_cnt <= blocked ? 64'h1 : 64'h2;
      else if (!blocked) ph_cnt <= ph_cnt + 64'h1;
    end
  end

  wire [63:0] snap_cycles = 64'(len_snap) * 64'(TICK_CYCLES);

  sequence s_up_first;
    accept && up_evt && (position == RS_POS_FIRST) && (eff_cnt > RS_POS_FIRST);
  endsequence

  sequence s_dn_last;
    accept && !up_evt && (position == eff_cnt) && (eff_cnt > RS_POS_FIRST);
  endsequence

  pos_range_a: assert property (@(posedge clk) disable iff (rst)
    (position >= RS_POS_FIRST) && (position <= RS_POS_LAST))
    else $error("position outside 1..32");

  high_outs_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_op && $stable(ctrl) |=> ((position_out & ~$past(pos_mask)) == 32'h0000_0000))
    else $error("output above position count driven");

  steady_out_a: assert property (@(posedge clk) disable iff (rst)
    (!rst && ctrl_op && !ctrl_pulsed && !blocked) |=> (position_out == $past(hot_masked)))
    else $error("steady output does not follow position");

  pulse_len_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_PULSE) && t_done && !blocked && ctrl_op && (state_q == ST_PULSE)
      |-> (ph_cnt == snap_cycles + 64'h1))
    else $error("pulse length wrong");

  delay_len_a: assert property (@(posedge clk) disable iff (rst)
    delay_end && ctrl_op && (state_q == ST_DELAY) |-> (ph_cnt == snap_cycles + 64'h1))
    else $error("activation delay wrong");

  hold_delay_a: assert property (@(posedge clk) disable iff (rst)
    accept |=> (state == ST_DELAY) && $stable(position))
    else $error("position moved before delay");

  wrap_up_a: assert property (@(posedge clk) disable iff (rst)
    s_up_first ##0 !ctrl_estop |=> (target == $past(eff_cnt)))
    else $error("up at first did not wrap to last");

  wrap_dn_a: assert property (@(posedge clk) disable iff (rst)
    s_dn_last ##0 !ctrl_estop |=> (target == RS_POS_FIRST))
    else $error("down at last did not wrap to first");

  end_stop_a: assert property (@(posedge clk) disable iff (rst)
    (s_up_first or s_dn_last) ##0 ctrl_estop |=> (target == $past(position)))
    else $error("end stop allowed a wrap");

  op_off_a: assert property (@(posedge clk) disable iff (rst)
    !ctrl_op |=> (state == ST_IDLE) && (position_out == 32'h0000_0000))
    else $error("switched off but still active");

  bin_cmd_a: assert property (@(posedge clk) disable iff (rst)
    (state == ST_IDLE) && ctrl_op && !blocked && bin_up_r |=> (state == ST_DELAY))
    else $error("binary input command not taken");

  block_hold_a: assert property (@(posedge clk) disable iff (rst)
    blocked && ctrl_op |=> $stable(position) && $stable(position_out))
    else $error("blocked switch changed");

endmodule

// ===== bench/rs_panel_model.sv
// Binary input source standing in for the external step switches
module rs_panel_model (
  // Clock
  input  wire logic clk,
  // Step pins
  output logic      bin_up,
  output logic      bin_down
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bin_up   = 1'b0;
    bin_down = 1'b0;
  end
  // --------
  // Press
  // --------
  // Caller spaces presses by delay plus pulse, else a step is dropped
  task automatic press(input logic up, input int hold);
    @(posedge clk);
    bin_up   <= up;
    bin_down <= !up;
    repeat (hold) @(posedge clk);
    bin_up   <= 1'b0;
    bin_down <= 1'b0;
  endtask
endmodule

// ===== bench/rs_selector_tb_top.sv
// Self-checking bench for the rotary selector switch
module rs_selector_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rs_pkg::*;
  localparam int TK = 4;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [3:0]  cmd;
    logic [5:0]  pos;
    logic [31:0] out;
  } rs_row_t;
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, bin_up, bin_down, block;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, position_out;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, place;
  logic [5:0]  position_number;
  int          err_total = 0;
  int          total_checks = 0;
  int          cyc = 0;
  rs_row_t     rows [10];

  rs_selector #(.TICK_CYCLES(TK)) i_dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bin_up(bin_up), .bin_down(bin_down), .block(block),
    .operator_place_select(place), .position_number(position_number),
    .position_out(position_out));
  rs_panel_model i_pan (.clk(clk), .bin_up(bin_up), .bin_down(bin_down));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // --------
  // Checks and bus cycles
  // --------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t: saw %h, want %h", $time, s, e);
    end
  endtask

  // Ready is read at the negedge, where it is settled for the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(negedge clk);
      {ta, tw, tb} = {awready & awvalid, wready & wvalid, bvalid & bready};
      if (tb) chk({30'h0, bresp}, {30'h0, er});
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(negedge clk);
      {ta, tr} = {arready & arvalid, rvalid & rready};
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end while (!tr);
  endtask

  task automatic step(input logic [31:0] c, input logic [3:0] m);
    wr(RS_REG_CTRL, c, RS_RESP_OKAY);
    wr(RS_REG_CMD, {28'h0, m}, RS_RESP_OKAY);
    repeat (40) @(posedge clk);
  endtask

  task automatic pos_is(input logic [5:0] p, input logic [31:0] o);
    @(negedge clk);
    chk({26'h0, position_number}, {26'h0, p});
    chk(position_out, o);
  endtask

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard, far above the roughly nine hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      give_verdict();
    end
  end

  // --------
  // Main sequence
  // --------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    {awvalid, wvalid, bready, arvalid, rready, block} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    place = RS_PLACE_ALL;
    rst = 1'b1;
    // Up steps downward in number: up at first goes to last
    rows = '{'{32'h2001, 4'h1, 6'd32, 32'h8000_0000}, '{32'h2001, 4'h2, 6'd1, 32'h1},
             '{32'h2005, 4'h1, 6'd1, 32'h1}, '{32'h2005, 4'h2, 6'd2, 32'h2},
             '{32'h2004, 4'h8, 6'd2, 32'h0}, '{32'h0305, 4'h8, 6'd3, 32'h4},
             '{32'h0305, 4'h8, 6'd3, 32'h4}, '{32'h0301, 4'h8, 6'd1, 32'h1},
             '{32'h0301, 4'h4, 6'd3, 32'h4}, '{32'h2001, 4'h4, 6'd2, 32'h2}};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(RS_REG_CTRL, d, r);
    chk(d, RS_CTRL_RESET);
    rd(RS_REG_PULSE, d, r);
    chk(d, {16'h0, RS_PULSE_RESET});
    rd(RS_REG_DELAY, d, r);
    chk(d, {16'h0, RS_DELAY_RESET});
    pos_is(6'd1, 32'h1);
    wr(RS_REG_DELAY, 32'h2, RS_RESP_OKAY);
    wr(RS_REG_PULSE, 32'h1, RS_RESP_OKAY);
    foreach (rows[i]) begin
      step(rows[i].ctrl, rows[i].cmd);
      pos_is(rows[i].pos, rows[i].out);
    end
    @(posedge clk);
    block <= 1'b1;
    step(32'h2001, 4'h1);
    pos_is(6'd2, 32'h2);
    rd(RS_REG_STATUS, d, r);
    chk(d, 32'h0002_0202);
    @(posedge clk);
    block <= 1'b0;
    place <= RS_PLACE_LOCAL;
    step(32'h2001, 4'h4);
    pos_is(6'd2, 32'h2);
    @(posedge clk);
    place <= RS_PLACE_REMOTE;
    step(32'h2001, 4'h1);
    step(32'h2001, 4'h8);
    pos_is(6'd3, 32'h4);
    @(posedge clk);
    place <= RS_PLACE_ALL;
    i_pan.press(1'b1, 4);
    pos_is(6'd3, 32'h4);
    repeat (30) @(posedge clk);
    pos_is(6'd2, 32'h2);
    wr(RS_REG_CTRL, 32'h2003, RS_RESP_OKAY);
    repeat (20) @(posedge clk);
    wr(RS_REG_CMD, 32'h1, RS_RESP_OKAY);
    n = 0;
    repeat (60) begin
      @(negedge clk);
      n += (position_out === 32'h1);
    end
    chk(32'(n), 32'(TK + 1));
    rd(8'h14, d, r);
    chk({d[29:0], r}, {30'h0, RS_RESP_SLVERR});
    rd(RS_REG_CMD, d, r);
    chk(d, 32'h0);
    wr(8'h20, 32'h1, RS_RESP_SLVERR);
    // Mid-run reset must restore settings and the steady output
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    pos_is(6'd1, 32'h1);
    rd(RS_REG_CTRL, d, r);
    chk(d, RS_CTRL_RESET);
    rd(RS_REG_PULSE, d, r);
    chk(d, {16'h0, RS_PULSE_RESET});
    give_verdict();
  end
endmodule
